// ==== design/isamc_pkg.sv ====
package isamc_pkg;

  // ---------------------------------------------------------------
  // Cycle timing, in bus clock periods
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_TO_RDY_16  = 4'h6;
  localparam logic [3:0] ADDR_TO_RDY_8   = 4'hC;
  localparam logic [3:0] ADDR_TO_DATA_16 = 4'h4;
  localparam logic [3:0] ADDR_TO_DATA_8  = 4'hA;
  localparam logic [3:0] CMD_TO_RDY_16   = 4'h2;
  localparam logic [3:0] CMD_TO_RDY_8    = 4'h5;
  localparam logic [3:0] CMD_TO_DATA_16  = 4'h2;
  localparam logic [3:0] CMD_TO_DATA_8   = 4'h5;
  localparam logic [3:0] RDY_TO_RDATA    = 4'h1;
  localparam logic [3:0] RDY_TO_WDATA    = 4'h2;
  localparam logic [3:0] RDY_TO_CMD_OFF  = 4'h1;
  localparam logic [3:0] RDY_TO_ADDR_CHG = 4'h2;
  localparam logic [3:0] WDATA_SETUP     = 4'h2;
  localparam logic [3:0] WDATA_HOLD      = 4'h1;
  localparam logic [3:0] CMD_OFF_TO_IO   = 4'h3;
  localparam logic [3:0] CMD_OFF_TO_ALE  = 4'h1;

  // Request kinds
  typedef enum logic [1:0] {
    ISAMC_MEM,
    ISAMC_SMEM,
    ISAMC_IO,
    ISAMC_REFRESH
  } isamc_kind_e;

endpackage : isamc_pkg

// ==== design/isamc_tick_if.sv ====
`timescale 1ns/1ps
// Bus clock edge tick and sampled ready shared between the sampler and sequencer
interface isamc_tick_if;
  logic       tick;
  logic       rdy;

  modport src (output tick, output rdy);
  modport dst (input tick, input rdy);
endinterface : isamc_tick_if

// ==== design/isamc_bclk_sync.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bus clock and ready sampler
// ---------------------------------------------------------------
module isamc_bclk_sync (
  input  wire logic  sys_clk_i,
  input  wire logic  sys_rst_i,
  input  wire logic  bclk_i,
  input  wire logic  iochrdy_i,
  isamc_tick_if.src  tk
);
  logic [2:0] bclk_sr;
  logic [1:0] rdy_sr;
  logic [2:0] next_bclk_sr;
  logic [1:0] next_rdy_sr;

  // Two stages before use; the third stage only feeds the edge detector
  always_comb
  begin
    next_bclk_sr = {bclk_sr[1:0], bclk_i};
    next_rdy_sr  = {rdy_sr[0], iochrdy_i};
  end

  // Bus clock chain runs through reset, so release gives no false edge
  always_ff @(posedge sys_clk_i)
  begin
    bclk_sr <= next_bclk_sr;
    if (sys_rst_i)
    begin
      rdy_sr  <= 2'h3;
    end
    else
    begin
      rdy_sr  <= next_rdy_sr;
    end
  end

  // One tick per rising bus clock edge
  assign tk.tick       = bclk_sr[1] & ~bclk_sr[2];
  assign tk.rdy        = rdy_sr[1];
endmodule : isamc_bclk_sync

// ==== design/isamc_seq.sv ====
`timescale 1ns/1ps
module isamc_seq (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        bclk_i,
  input  wire logic        iochrdy_i,
  input  wire logic        req_i,
  input  wire logic [1:0]  req_kind_i,
  input  wire logic        req_write_i,
  input  wire logic        req_8bit_i,
  input  wire logic        req_copy_i,
  input  wire logic [19:0] req_addr_i,
  input  wire logic        req_bhe_i,
  input  wire logic [15:0] req_wdata_i,
  input  wire logic [15:0] sd_i,
  output logic             req_ready_o,
  output logic             done_o,
  output logic [15:0]      rdata_o,
  output logic             ale_o,
  output logic [19:0]      sa_o,
  output logic             sbhe_n_o,
  output logic             memr_n_o,
  output logic             memw_n_o,
  output logic             smemr_n_o,
  output logic             smemw_n_o,
  output logic             ior_n_o,
  output logic             iow_n_o,
  output logic [15:0]      sd_o,
  output logic             sd_lo_oe_o,
  output logic             sd_hi_oe_o
);

  // ---------------------------------------------------------------
  // Sampling of the bus clock and ready
  // ---------------------------------------------------------------
  isamc_tick_if tk ();

  isamc_bclk_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .bclk_i    (bclk_i),
    .iochrdy_i (iochrdy_i),
    .tk        (tk)
  );

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ISAMC_IDLE,
    ISAMC_SETUP,
    ISAMC_CMD,
    ISAMC_END,
    ISAMC_HOLD
  } isamc_state_e;

  isamc_state_e state;
  isamc_state_e next_state;
  logic [3:0]   addr_cnt;
  logic [3:0]   next_addr_cnt;
  logic [3:0]   cmd_cnt;
  logic [3:0]   next_cmd_cnt;
  logic [3:0]   gap_cnt;
  logic [3:0]   next_gap_cnt;
  logic [1:0]   kind;
  logic [1:0]   next_kind;
  logic         wr;
  logic         next_wr;
  logic         b8;
  logic         next_b8;
  logic [15:0]  sd_meta;
  logic [15:0]  sd_sync;
  logic [19:0]  next_sa;
  logic         next_sbhe_n;
  logic [15:0]  next_sd;
  logic         next_lo_oe;
  logic         next_hi_oe;
  logic         cmd_on;
  logic         next_cmd_on;
  logic         next_ale;
  logic [15:0]  next_rdata;
  logic         next_done;
  logic         next_req_ready;
  logic         rd_taken;
  logic         next_rd_taken;

  // Saturating increment for interval counters
  function automatic logic [3:0] isamc_inc(input logic [3:0] v);
    isamc_inc = (v == 4'hF) ? v : v + 4'h1;
  endfunction : isamc_inc

  // Least wait chosen by slave width
  function automatic logic [3:0] isamc_pick(input logic       is8,
                                            input logic [3:0] w16,
                                            input logic [3:0] w8);
    isamc_pick = is8 ? w8 : w16;
  endfunction : isamc_pick

  logic rdy_ok;
  logic io_ok;
  logic is_read;

  // Ready is believed only once both address and strobe windows expire
  assign rdy_ok = tk.rdy
    && addr_cnt >= isamc_pick(b8, isamc_pkg::ADDR_TO_RDY_16,
                              isamc_pkg::ADDR_TO_RDY_8)
    && cmd_cnt >= isamc_pick(b8, isamc_pkg::CMD_TO_RDY_16,
                             isamc_pkg::CMD_TO_RDY_8)
    && addr_cnt >= isamc_pick(b8, isamc_pkg::ADDR_TO_DATA_16,
                              isamc_pkg::ADDR_TO_DATA_8)
    && cmd_cnt >= isamc_pick(b8, isamc_pkg::CMD_TO_DATA_16,
                             isamc_pkg::CMD_TO_DATA_8);
  assign io_ok  = gap_cnt >= isamc_pkg::CMD_OFF_TO_IO;
  assign is_read = ~wr;

  // Next-state and datapath; every counter moves only on a bus tick
  always_comb
  begin
    next_state     = state;
    next_addr_cnt  = addr_cnt;
    next_cmd_cnt   = cmd_cnt;
    next_gap_cnt   = gap_cnt;
    next_kind      = kind;
    next_wr        = wr;
    next_b8        = b8;
    next_sa        = sa_o;
    next_sbhe_n    = sbhe_n_o;
    next_sd        = sd_o;
    next_lo_oe     = sd_lo_oe_o;
    next_hi_oe     = sd_hi_oe_o;
    next_cmd_on    = cmd_on;
    next_ale       = 1'b0;
    next_rdata     = rdata_o;
    next_done      = 1'b0;
    next_req_ready = 1'b0;
    next_rd_taken  = rd_taken;
    if (tk.tick)
    begin
      next_addr_cnt = isamc_inc(addr_cnt);
      next_cmd_cnt  = isamc_inc(cmd_cnt);
      next_gap_cnt  = isamc_inc(gap_cnt);
      unique case (state)
        ISAMC_IDLE:
        begin
          // Address latch waits out strobe recovery
          if (req_i && gap_cnt >= isamc_pkg::CMD_OFF_TO_ALE)
          begin
            next_kind     = req_kind_i;
            next_wr       = req_write_i;
            next_b8       = req_8bit_i;
            next_sa       = req_addr_i;
            next_sbhe_n   = ~req_bhe_i;
            next_ale      = 1'b1;
            next_addr_cnt = 4'h0;
            next_rd_taken = 1'b0;
            if (req_write_i)
            begin
              // Copy of the odd byte onto the low lane
              next_sd    = req_copy_i ? {req_wdata_i[15:8],
                                         req_wdata_i[15:8]} : req_wdata_i;
              next_lo_oe = 1'b1;
              next_hi_oe = ~req_8bit_i | req_copy_i;
            end
            next_cmd_cnt   = 4'h0;
            next_req_ready = 1'b1;
            next_state     = ISAMC_SETUP;
          end
        end
        ISAMC_SETUP:
        begin
          // Write data has led the strobe by two ticks
          if ((!wr || cmd_cnt >= isamc_pkg::WDATA_SETUP - 4'h1)
              && (kind != 2'(isamc_pkg::ISAMC_IO) || io_ok))
          begin
            next_cmd_on  = 1'b1;
            next_cmd_cnt = 4'h0;
            next_state   = ISAMC_CMD;
          end
        end
        ISAMC_CMD:
        begin
          if (rdy_ok)
          begin
            next_cmd_cnt = 4'h0;
            next_state   = ISAMC_END;
          end
        end
        ISAMC_END:
        begin
          // Read data taken one tick after ready, while the strobe is
          // still on, since the slave may float at negation
          if (is_read && !rd_taken
              && cmd_cnt >= isamc_pkg::RDY_TO_RDATA - 4'h1)
          begin
            next_rdata    = b8 ? {8'h00, sd_sync[7:0]} : sd_sync;
            next_rd_taken = 1'b1;
          end
          // Strobe kept on for a tick past ready
          if (cmd_cnt >= isamc_pkg::RDY_TO_CMD_OFF - 4'h1)
          begin
            next_cmd_on  = 1'b0;
            next_gap_cnt = 4'h0;
            next_state   = ISAMC_HOLD;
          end
        end
        ISAMC_HOLD:
        begin
          // Write data kept one tick past strobe
          if (gap_cnt >= isamc_pkg::WDATA_HOLD - 4'h1)
          begin
            next_lo_oe = 1'b0;
            next_hi_oe = 1'b0;
          end
          // Address held, next latch delayed
          if (cmd_cnt >= isamc_pkg::RDY_TO_ADDR_CHG - 4'h1
              && cmd_cnt >= isamc_pkg::RDY_TO_WDATA - 4'h1)
          begin
            next_done  = 1'b1;
            next_state = ISAMC_IDLE;
          end
        end
        default:
        begin
          next_state = ISAMC_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers; strobes decoded from the kind into flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    // Bus data passes two stages; the strobe is still on when it is used
    sd_meta     <= sd_i;
    sd_sync     <= sd_meta;
    if (sys_rst_i)
    begin
      state       <= ISAMC_IDLE;
      addr_cnt    <= 4'h0;
      cmd_cnt     <= 4'h0;
      gap_cnt     <= 4'hF;
      kind        <= 2'h0;
      wr          <= 1'b0;
      b8          <= 1'b0;
      sa_o        <= 20'h00000;
      sbhe_n_o    <= 1'b1;
      sd_o        <= 16'h0000;
      sd_lo_oe_o  <= 1'b0;
      sd_hi_oe_o  <= 1'b0;
      cmd_on      <= 1'b0;
      ale_o       <= 1'b0;
      rdata_o     <= 16'h0000;
      done_o      <= 1'b0;
      req_ready_o <= 1'b0;
      rd_taken    <= 1'b0;
      memr_n_o    <= 1'b1;
      memw_n_o    <= 1'b1;
      smemr_n_o   <= 1'b1;
      smemw_n_o   <= 1'b1;
      ior_n_o     <= 1'b1;
      iow_n_o     <= 1'b1;
    end
    else
    begin
      state       <= next_state;
      addr_cnt    <= next_addr_cnt;
      cmd_cnt     <= next_cmd_cnt;
      gap_cnt     <= next_gap_cnt;
      kind        <= next_kind;
      wr          <= next_wr;
      b8          <= next_b8;
      sa_o        <= next_sa;
      sbhe_n_o    <= next_sbhe_n;
      sd_o        <= next_sd;
      sd_lo_oe_o  <= next_lo_oe;
      sd_hi_oe_o  <= next_hi_oe;
      cmd_on      <= next_cmd_on;
      ale_o       <= next_ale;
      rdata_o     <= next_rdata;
      done_o      <= next_done;
      req_ready_o <= next_req_ready;
      rd_taken    <= next_rd_taken;
      // Refresh drives both memory read strobes
      memr_n_o  <= ~(next_cmd_on && !next_wr
                     && (next_kind == 2'(isamc_pkg::ISAMC_MEM)
                      || next_kind == 2'(isamc_pkg::ISAMC_REFRESH)));
      memw_n_o  <= ~(next_cmd_on && next_wr
                     && next_kind == 2'(isamc_pkg::ISAMC_MEM));
      smemr_n_o <= ~(next_cmd_on && !next_wr
                     && (next_kind == 2'(isamc_pkg::ISAMC_SMEM)
                      || next_kind == 2'(isamc_pkg::ISAMC_REFRESH)));
      smemw_n_o <= ~(next_cmd_on && next_wr
                     && next_kind == 2'(isamc_pkg::ISAMC_SMEM));
      ior_n_o   <= ~(next_cmd_on && !next_wr
                     && next_kind == 2'(isamc_pkg::ISAMC_IO));
      iow_n_o   <= ~(next_cmd_on && next_wr
                     && next_kind == 2'(isamc_pkg::ISAMC_IO));
    end
  end

endmodule : isamc_seq

// ==== sim/isamc_seq_asserts.sv ====
`timescale 1ns/1ps
module isamc_seq_asserts (
  input logic        sys_clk_i,
  input logic        sys_rst_i,
  input logic        bclk_i,
  input logic        iochrdy_i,
  input logic        req_8bit_i,
  input logic        ale_o,
  input logic [19:0] sa_o,
  input logic        memr_n_o,
  input logic        memw_n_o,
  input logic        smemr_n_o,
  input logic        smemw_n_o,
  input logic        ior_n_o,
  input logic        iow_n_o,
  input logic        sd_lo_oe_o,
  input logic        sd_hi_oe_o
);
  // ---------------------------------------------------------------
  // Tick counters
  // ---------------------------------------------------------------
  logic       bq, rq, w8, tk, cmd_n, wr_n, io_n;
  logic [3:0] t_ale, t_on, t_off, t_rdy;
  assign io_n  = ior_n_o & iow_n_o;
  assign wr_n  = memw_n_o & smemw_n_o & iow_n_o;
  assign cmd_n = memr_n_o & memw_n_o & smemr_n_o & smemw_n_o & io_n;
  assign tk    = bclk_i & !bq;
  function automatic logic [3:0] inc(input logic [3:0] t);
    return (tk && t != 4'hF) ? t + 4'h1 : t;
  endfunction : inc
  // Saturate so that long idle spans read as satisfied; t_rdy also
  // counts the tick on which ready is first seen, hence one extra
  always_ff @(posedge sys_clk_i)
  begin
    bq <= bclk_i;
    rq <= iochrdy_i;
    w8 <= ale_o ? req_8bit_i : w8;
    t_ale <= ale_o ? 4'h0 : inc(t_ale);
    t_on <= cmd_n ? 4'h0 : inc(t_on);
    t_off <= (sys_rst_i || cmd_n) ? inc(t_off) | {4{sys_rst_i}} : 4'h0;
    t_rdy <= (sys_rst_i || !(iochrdy_i && !rq)) ?
             inc(t_rdy) | {4{sys_rst_i}} : 4'h0;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rdy_wait;
    $rose(cmd_n) |-> t_ale >= (w8 ? 4'hD : 4'h7);
  endproperty
  property p_cmd_wait;
    $rose(cmd_n) |-> t_on >= (w8 ? 4'h5 : 4'h2);
  endproperty
  property p_rdy_hold;
    $rose(cmd_n) |-> t_rdy >= 4'h2;
  endproperty
  property p_ale_rdy;
    $rose(ale_o) |-> t_rdy >= 4'h3 ##1 !ale_o;
  endproperty
  property p_addr_hold;
    $changed(sa_o) |-> t_rdy >= 4'h3;
  endproperty
  property p_wd_setup;
    $fell(wr_n) |-> t_ale >= 4'h2 && sd_lo_oe_o;
  endproperty
  property p_wd_hold;
    $rose(wr_n) |-> sd_lo_oe_o [*8];
  endproperty
  property p_io_gap;
    $fell(io_n) |-> t_off >= 4'h3;
  endproperty
  property p_ale_off;
    $rose(ale_o) |-> t_off >= 4'h1;
  endproperty
  property p_oe_hold;
    ($fell(sd_lo_oe_o) || $fell(sd_hi_oe_o)) |-> t_off >= 4'h1;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait)
    else $error("strobe ended too soon after address");
  a_cmd_wait: assert property (p_cmd_wait)
    else $error("strobe ended too soon after assertion");
  a_rdy_hold: assert property (p_rdy_hold)
    else $error("strobe ended too soon after ready");
  a_ale_rdy: assert property (p_ale_rdy)
    else $error("latch enable too soon after ready");
  a_addr_hold: assert property (p_addr_hold)
    else $error("address changed too soon after ready");
  a_wd_setup: assert property (p_wd_setup)
    else $error("write data late before strobe");
  a_wd_hold: assert property (p_wd_hold)
    else $error("write data dropped with strobe");
  a_io_gap: assert property (p_io_gap)
    else $error("io strobe too soon after strobe off");
  a_ale_off: assert property (p_ale_off)
    else $error("latch enable too soon after strobe off");
  a_oe_hold: assert property (p_oe_hold)
    else $error("write data released too soon after strobe off");
  c_read: cover property ($fell(memr_n_o) && !smemr_n_o);
  c_iow: cover property ($fell(iow_n_o));
  c_wait: cover property ($fell(iochrdy_i) && !cmd_n);
endmodule : isamc_seq_asserts
bind isamc_seq isamc_seq_asserts u_chk (.sys_clk_i, .sys_rst_i, .bclk_i,
  .iochrdy_i, .req_8bit_i, .ale_o, .sa_o, .memr_n_o, .memw_n_o,
  .smemr_n_o, .smemw_n_o, .ior_n_o, .iow_n_o, .sd_lo_oe_o, .sd_hi_oe_o);

// ==== sim/isamc_slave_model.sv ====
`timescale 1ns/1ps
module isamc_slave_model (
  input  logic        bclk_i,
  input  logic [19:0] sa_i,
  input  logic        memr_n_i,
  input  logic        memw_n_i,
  input  logic        smemr_n_i,
  input  logic        smemw_n_i,
  input  logic        ior_n_i,
  input  logic        iow_n_i,
  input  logic [15:0] bus_i,
  input  logic [3:0]  waits_i,
  output logic        iochrdy_o,
  output logic [15:0] sd_o,
  output logic [15:0] wd_o
);
  // ---------------------------------------------------------------
  // Slave: wait states, read data, write capture
  // ---------------------------------------------------------------
  logic        rd, act;
  logic        armed = 1'b1;
  logic [3:0]  n = 4'h0;
  logic [15:0] last = 16'h0;
  assign rd  = !(memr_n_i & smemr_n_i & ior_n_i);
  assign act = rd | !(memw_n_i & smemw_n_i & iow_n_i);
  // Wait states counted on bus clock falls, so ready moves mid-period
  always @(negedge bclk_i)
  begin
    armed <= !act;
    n <= armed ? waits_i : n - {3'h0, n != 4'h0};
  end
  assign iochrdy_o = !(act && (armed ? waits_i != 4'h0 : n != 4'h0));
  // Data floats at strobe off: show the inverse, not a stale copy
  always @(negedge rd) last <= sa_i[15:0] ^ 16'h3C5A;
  assign sd_o = rd ? sa_i[15:0] ^ 16'h3C5A : ~last;
  // Captured well after strobe off, inside the required hold
  always @(posedge memw_n_i or posedge smemw_n_i or posedge iow_n_i)
  begin
    #40 wd_o = bus_i;
  end
endmodule : isamc_slave_model

// ==== sim/isa_master_cycle_timing_tb.sv ====
`timescale 1ns/1ps
module isa_master_cycle_timing_tb;
  // ---------------------------------------------------------------
  // Bench signals
  // ---------------------------------------------------------------
  logic sys_clk_i = 0, sys_rst_i = 1, bclk_i = 0, req_i = 0, req_write_i = 0;
  logic req_8bit_i = 0, req_copy_i = 0, req_bhe_i = 0, iochrdy_i;
  logic [1:0] req_kind_i = 2'h0;
  logic [19:0] req_addr_i = 20'h0, sa_o;
  logic [15:0] req_wdata_i = 16'h0, sd_i, sd_o, rdata_o, slv_sd, slv_wd;
  logic [3:0] waits = 4'h0;
  logic req_ready_o, done_o, ale_o, sbhe_n_o, memr_n_o, memw_n_o, smemr_n_o;
  logic smemw_n_o, ior_n_o, iow_n_o, sd_lo_oe_o, sd_hi_oe_o;
  int err_count = 0, samples_checked = 0;
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  // Bus clock, phase unrelated to the system clock
  initial
  begin
    #7;
    forever #80 bclk_i = ~bclk_i;
  end
  assign sd_i = {sd_hi_oe_o ? sd_o[15:8] : slv_sd[15:8],
                 sd_lo_oe_o ? sd_o[7:0] : slv_sd[7:0]};
  isamc_seq DUT (.sys_clk_i, .sys_rst_i, .bclk_i, .iochrdy_i, .req_i,
    .req_kind_i, .req_write_i, .req_8bit_i, .req_copy_i, .req_addr_i,
    .req_bhe_i, .req_wdata_i, .sd_i, .req_ready_o, .done_o, .rdata_o,
    .ale_o, .sa_o, .sbhe_n_o, .memr_n_o, .memw_n_o, .smemr_n_o, .smemw_n_o,
    .ior_n_o, .iow_n_o, .sd_o, .sd_lo_oe_o, .sd_hi_oe_o);
  isamc_slave_model slv (.bclk_i, .sa_i(sa_o), .memr_n_i(memr_n_o),
    .memw_n_i(memw_n_o), .smemr_n_i(smemr_n_o), .smemw_n_i(smemw_n_o),
    .ior_n_i(ior_n_o), .iow_n_i(iow_n_o), .bus_i(sd_i), .waits_i(waits),
    .iochrdy_o(iochrdy_i), .sd_o(slv_sd), .wd_o(slv_wd));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Request held until accepted, then wait for the end under a bound
  task automatic run(input logic [1:0] k, input logic w, b, c,
                     input logic [19:0] a, input logic [15:0] d,
                     input logic [3:0] ws);
    int n;
    n = 0;
    {req_kind_i, req_write_i, req_8bit_i, req_copy_i} = {k, w, b, c};
    {req_addr_i, req_wdata_i, waits, req_i} = {a, d, ws, 1'b1};
    req_bhe_i = !b | a[0];
    while (req_ready_o !== 1'b1 && n < 4000)
    begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    req_i = 0;
    while (done_o !== 1'b1 && n < 8000)
    begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    chk("completion", 16'h0, {15'h0, n >= 8000});
    chk("sbhe_n", {15'h0, !req_bhe_i}, {15'h0, sbhe_n_o});
  endtask : run
  // Memory, system memory and I/O at both widths, waits from none to five, back to back
  task automatic t_reads;
    logic [19:0] a;
    for (int i = 0; i < 6; i++)
    begin
      a = 20'hA4C40 + 20'(i * 6);
      run(2'(i % 3), 0, i > 2, 0, a, 16'h0, 4'(i));
      chk("rdata", i > 2 ? {8'h0, a[7:0] ^ 8'h5A} : a[15:0] ^ 16'h3C5A,
          rdata_o);
    end
  endtask : t_reads
  task automatic t_writes;
    logic [15:0] d;
    for (int i = 0; i < 6; i++)
    begin
      d = 16'h9E17 + 16'(i * 16'h1111);
      run(2'(i % 3), 1, i > 2, 0, 20'h00300 + 20'(i * 2), d, 4'(i));
      chk("wdata", i > 2 ? {8'h0, d[7:0]} : d,
          i > 2 ? {8'h0, slv_wd[7:0]} : slv_wd);
    end
  endtask : t_writes
  task automatic t_refresh;
    run(2'h3, 0, 0, 0, 20'h00000, 16'h0, 4'h2);
  endtask : t_refresh
  task automatic t_copy;
    run(2'h0, 1, 1, 1, 20'h00341, 16'hC300, 4'h1);
    chk("copy", 16'h00C3, {8'h0, slv_wd[7:0]});
  endtask : t_copy
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    #1 sys_rst_i = 0;
    t_reads;
    t_writes;
    t_refresh;
    t_copy;
    tally_and_finish;
  end
  // Watchdog: the tests need some 30 us
  initial
  begin
    #400us;
    err_count++;
    tally_and_finish;
  end
endmodule : isa_master_cycle_timing_tb
